// file: hw/ldc_params.svh
// Register offsets, field positions and reset values of the LED driver configuration bank
// Functional notes
// - LED function stays disabled while chip enable bit 6 of register 0 is 0.
// - Enable control register at address 0h, resets to 0h, device starts disabled.
// - Option control register at address 1h, resets 3Ch; upper two bits reserved, RW.
// - Option bit 5 selects dimming curve: 0 linear, 1 logarithmic; resets 1.
// - Option bit 4 enables automatic power saving; resets 1.
// - Option bit 3 enables register address auto-increment; resets 1.
// - Option bit 2 enables PWM dithering; resets 1.
// - Option bit 1 current ceiling: 0 is 25.5 mA, 1 is 35 mA; resets 0.
// - Option bit 0 forces every LED output off, overriding all; resets 0.
// - Low bank select register at address 2h, resets 00h.
// - Low bank select bit n puts module n in bank control when 1.
// - High bank select register at address 3h, resets 00h; bits 7 to 4 reserved RW.
// - High bank select bit 3 puts module eleven in bank control when 1.
// - High bank select bits 2..0 steer modules ten, nine, eight likewise.
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define LDC_ADDR_ENABLE      8'h00
`define LDC_ADDR_OPTION      8'h01
`define LDC_ADDR_BANK_LO     8'h02
`define LDC_ADDR_BANK_HI     8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LDC_RST_ENABLE       8'h00
`define LDC_RST_OPTION       8'h3C
`define LDC_RST_BANK_LO      8'h00
`define LDC_RST_BANK_HI      8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LDC_BIT_CHIP_EN      6
`define LDC_BIT_LOG_SCALE    5
`define LDC_BIT_POWER_SAVE   4
`define LDC_BIT_AUTO_INCR    3
`define LDC_BIT_DITHER       2
`define LDC_BIT_MAX_CURRENT  1
`define LDC_BIT_SHUTDOWN     0
`define LDC_BANK_HI_USED     4

`endif

// file: hw/ldc_pkg.sv
// Types shared by the LED driver configuration bank
package ldc_pkg;

  // ----------------------------------------
  // Host access
  // ----------------------------------------
  typedef struct packed {
    logic       start;
    logic       wr_valid;
    logic       rd_valid;
    logic [7:0] start_addr;
    logic [7:0] wdata;
  } ldc_req_t;

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  typedef struct packed {
    logic        led_enable;
    logic        log_scale;
    logic        power_save;
    logic        dither;
    logic        high_current;
    logic [11:0] group_mode;
  } ldc_ctrl_t;

  typedef enum logic [1:0] {
    LDC_ST_IDLE = 2'b01,
    LDC_ST_XFER = 2'b10
  } ldc_state_t;

endpackage

// file: hw/ldc_regs.sv
// Configuration register bank of a multi-channel LED sink driver
`timescale 1ns/10ps
`include "ldc_params.svh"

module ldc_regs (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Byte access from the serial front end
  input  wire ldc_pkg::ldc_req_t req,
  // Read data and current pointer
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic [7:0]             cur_addr,
  // Controls to the LED datapath
  output ldc_pkg::ldc_ctrl_t     ctrl
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]          device_enable_ctrl_reg, device_enable_ctrl_next;
  logic [7:0]          device_option_ctrl_reg, device_option_ctrl_next;
  logic [7:0]          bank_select_low_reg, bank_select_low_next;
  logic [7:0]          bank_select_high_reg, bank_select_high_next;
  logic [7:0]          addr_reg, addr_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic                rvalid_reg, rvalid_next;
  ldc_pkg::ldc_state_t state_reg, state_next;
  ldc_pkg::ldc_ctrl_t  ctrl_reg, ctrl_next;

  // ----------------------------------------
  // Decoded byte
  // ----------------------------------------
  logic [7:0]          acc_addr;
  logic                byte_done;
  logic                wr_taken;
  logic                rd_taken;
  logic [3:0]          acc_sel;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // One-hot select of the four registers, all zero outside this bank
  function automatic logic [3:0] reg_select(input logic [7:0] a);
    if (a == `LDC_ADDR_ENABLE) begin
      reg_select = 4'h1;
    end else if (a == `LDC_ADDR_OPTION) begin
      reg_select = 4'h2;
    end else if (a == `LDC_ADDR_BANK_LO) begin
      reg_select = 4'h4;
    end else if (a == `LDC_ADDR_BANK_HI) begin
      reg_select = 4'h8;
    end else begin
      reg_select = 4'h0;
    end
  endfunction

  // Read data of the selected register
  function automatic logic [7:0] read_mux(input logic [3:0] s, input logic [7:0] e,
                                          input logic [7:0] o, input logic [7:0] l,
                                          input logic [7:0] h);
    if (s[0]) begin
      read_mux = e;
    end else if (s[1]) begin
      read_mux = o;
    end else if (s[2]) begin
      read_mux = l;
    end else if (s[3]) begin
      read_mux = h;
    end else begin
      // Registers outside this bank read as zero here
      read_mux = 8'h00;
    end
  endfunction

  // Whole byte replaced on a hit, reserved bits included
  function automatic logic [7:0] store_byte(input logic hit, input logic [7:0] d, input logic [7:0] q);
    if (hit) begin
      store_byte = d;
    end else begin
      store_byte = q;
    end
  endfunction

  // ----------------------------------------
  // Byte decode
  // ----------------------------------------
  always_comb begin
    // A start restarts the pointer even mid-transfer
    acc_addr  = req.start ? req.start_addr : addr_reg;
    // Bytes with no start since reset are dropped
    byte_done = (req.wr_valid | req.rd_valid) & (req.start | (state_reg == ldc_pkg::LDC_ST_XFER));
    // A write wins when both strobes are high
    wr_taken  = byte_done & req.wr_valid;
    rd_taken  = byte_done & ~req.wr_valid;
    acc_sel   = reg_select(acc_addr);
  end

  // ----------------------------------------
  // Transfer state and pointer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    case (state_reg)
      ldc_pkg::LDC_ST_IDLE: begin
        if (req.start) begin
          state_next = ldc_pkg::LDC_ST_XFER;
        end
      end
      ldc_pkg::LDC_ST_XFER: begin
        // No stop condition reaches this bank, so the transfer lasts until reset
        state_next = ldc_pkg::LDC_ST_XFER;
      end
      default: begin
        state_next = ldc_pkg::LDC_ST_IDLE;
      end
    endcase
    if (byte_done) begin
      // Increment mode is taken before this byte's own write lands
      if (device_option_ctrl_reg[`LDC_BIT_AUTO_INCR]) begin
        addr_next = acc_addr + 8'h01;
      end else begin
        addr_next = acc_addr;
      end
    end else if (req.start) begin
      addr_next = req.start_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ldc_pkg::LDC_ST_IDLE;
      addr_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_comb begin
    // Writes outside the bank hit nothing, yet the pointer still steps when auto-increment is on
    device_enable_ctrl_next = store_byte(wr_taken & acc_sel[0], req.wdata, device_enable_ctrl_reg);
    device_option_ctrl_next = store_byte(wr_taken & acc_sel[1], req.wdata, device_option_ctrl_reg);
    bank_select_low_next    = store_byte(wr_taken & acc_sel[2], req.wdata, bank_select_low_reg);
    bank_select_high_next   = store_byte(wr_taken & acc_sel[3], req.wdata, bank_select_high_reg);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      device_enable_ctrl_reg <= `LDC_RST_ENABLE;
      device_option_ctrl_reg <= `LDC_RST_OPTION;
      bank_select_low_reg    <= `LDC_RST_BANK_LO;
      bank_select_high_reg   <= `LDC_RST_BANK_HI;
    end else begin
      device_enable_ctrl_reg <= device_enable_ctrl_next;
      device_option_ctrl_reg <= device_option_ctrl_next;
      bank_select_low_reg    <= bank_select_low_next;
      bank_select_high_reg   <= bank_select_high_next;
    end
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (rd_taken) begin
      // Reserved bits come back as stored
      rdata_next  = read_mux(acc_sel, device_enable_ctrl_reg, device_option_ctrl_reg,
                             bank_select_low_reg, bank_select_high_reg);
      rvalid_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // Datapath controls
  // ----------------------------------------
  // Controls follow the stored fields; shutdown and chip enable gate only led_enable
  always_comb begin
    ctrl_next.led_enable   = device_enable_ctrl_reg[`LDC_BIT_CHIP_EN] &
                             ~device_option_ctrl_reg[`LDC_BIT_SHUTDOWN];
    ctrl_next.log_scale    = device_option_ctrl_reg[`LDC_BIT_LOG_SCALE];
    ctrl_next.power_save   = device_option_ctrl_reg[`LDC_BIT_POWER_SAVE];
    ctrl_next.dither       = device_option_ctrl_reg[`LDC_BIT_DITHER];
    ctrl_next.high_current = device_option_ctrl_reg[`LDC_BIT_MAX_CURRENT];
    // Only the used low nibble of the high bank register reaches the datapath
    ctrl_next.group_mode   = {bank_select_high_reg[`LDC_BANK_HI_USED-1:0], bank_select_low_reg};
  end

  // Registered copy costs one cycle of lag but keeps the outputs glitch free
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata    = rdata_reg;
  assign rvalid   = rvalid_reg;
  assign cur_addr = addr_reg;
  assign ctrl     = ctrl_reg;

endmodule

// file: test/ldc_regs_checker.sv
// Port assertions for the LED driver configuration bank
`timescale 1ns/10ps
module ldc_regs_checker (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               sys_rst,
  // Host side and results
  input wire ldc_pkg::ldc_req_t  req,
  input wire logic [7:0]         rdata,
  input wire logic               rvalid,
  input wire logic [7:0]         cur_addr,
  input wire ldc_pkg::ldc_ctrl_t ctrl
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> cur_addr == 8'h00 && !rvalid)
    else $error("pointer not cleared");
  a_read_answer: assert property (req.start && req.rd_valid && !req.wr_valid |=> rvalid)
    else $error("read not answered");
  a_start_load: assert property (req.start && !req.wr_valid && !req.rd_valid |=> cur_addr == $past(req.start_addr))
    else $error("pointer not loaded");
  a_idle_hold: assert property (!req.start && !req.wr_valid && !req.rd_valid |=> $stable(cur_addr))
    else $error("pointer moved while idle");
  a_option_copy: assert property (rvalid && $past(cur_addr) == 8'h01 && !$past(req.start) |->
    {ctrl.log_scale, ctrl.power_save, ctrl.dither, ctrl.high_current} == {rdata[5:4], rdata[2:1]})
    else $error("option controls differ");
  a_group_low: assert property (rvalid && $past(cur_addr) == 8'h02 && !$past(req.start) |->
    ctrl.group_mode[7:0] == rdata) else $error("low group modes differ");
  a_group_high: assert property (rvalid && $past(cur_addr) == 8'h03 && !$past(req.start) |->
    ctrl.group_mode[11:8] == rdata[3:0]) else $error("high group modes differ");
  a_incr_step: assert property (rvalid && $past(cur_addr) == 8'h01 && !$past(req.start) |->
    cur_addr == (rdata[3] ? 8'h02 : 8'h01)) else $error("pointer step wrong");
endmodule
bind ldc_regs ldc_regs_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .cur_addr(cur_addr), .ctrl(ctrl));

// file: test/ldc_host.sv
// Host model issuing byte requests
`timescale 1ns/10ps
module ldc_host (
  // Clock
  input wire logic          core_clk,
  // Requests
  output ldc_pkg::ldc_req_t req
);
  initial req = '0;
  // Start reloads the pointer, later bytes follow it
  task automatic xfer(input logic st, input logic wr, input logic [7:0] a, input logic [7:0] d);
    req <= '{start: st, wr_valid: wr, rd_valid: !wr, start_addr: a, wdata: d};
    @(posedge core_clk);
  endtask
  // Bare start: loads the pointer, carries no byte
  task automatic aim(input logic [7:0] a);
    req <= '{start: 1'b1, wr_valid: 1'b0, rd_valid: 1'b0, start_addr: a, wdata: 8'h00};
    @(posedge core_clk);
  endtask
  task automatic idle();
    req <= '0;
    @(posedge core_clk);
  endtask
endmodule

// file: test/test_ldc_regs.sv
// Self-checking bench for the LED driver configuration bank
`timescale 1ns/10ps
module test_ldc_regs;
  logic               core_clk = 1'b0;
  logic               sys_rst = 1'b1;
  ldc_pkg::ldc_req_t  req;
  logic [7:0]         rdata, cur_addr, ptr, q[$], m[4];
  logic               rvalid, go;
  logic [31:0]        r;
  ldc_pkg::ldc_ctrl_t ctrl;
  int                 num_errors = 0, comparisons = 0, cycles = 0, seed = 32'hb733;
  always #5 core_clk = ~core_clk;
  ldc_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .cur_addr(cur_addr), .ctrl(ctrl));
  ldc_host u_host (.core_clk(core_clk), .req(req));
  task automatic chk(input string s, input logic [24:0] e, input logic [24:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic op(input logic st, input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic inc;
    inc = m[1][3];
    if (st) ptr = a;
    if (wr && ptr < 4) m[ptr[1:0]] = d;
    if (!wr) q.push_back(ptr < 4 ? m[ptr[1:0]] : 8'h00);
    if (inc) ptr = ptr + 8'h01;
    u_host.xfer(st, wr, a, d);
  endtask
  task automatic settle();
    u_host.idle();
    u_host.idle();
    chk("cur_addr", {17'h0, ptr}, {17'h0, cur_addr});
    chk("ctrl", {8'h0, m[0][6] & ~m[1][0], m[1][5], m[1][4], m[1][2], m[1][1], m[3][3:0], m[2]}, {8'h0, ctrl});
  endtask
  task automatic do_reset(input int n);
    sys_rst <= 1'b1;
    repeat (n) @(posedge core_clk);
    sys_rst <= 1'b0;
    m = '{8'h00, 8'h3C, 8'h00, 8'h00};
    ptr = 8'h00;
    q.delete();
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) op(i == 0, 1'b0, 8'h00, 8'h00);
    settle();
    $display("reset values done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (rvalid === 1'b1) begin
      chk("rdata", {17'h0, q.size() > 0 ? q[0] : 8'hXX}, {17'h0, rdata});
      if (q.size() > 0) void'(q.pop_front());
    end
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    do_reset(12);
    // Random bursts mix writes, reads, unmapped places and auto-increment changes
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      go = r[9];
      // Now and then a bare start loads the pointer ahead of the bytes
      if (go) begin
        ptr = 8'(r[31:16] % 16'h0006);
        u_host.aim(ptr);
      end
      for (int j = 0; j < 4; j++) begin
        r = $random(seed);
        op(j == 0 && !go, r[8], 8'(r[31:16] % 16'h0006), r[7:0]);
      end
      settle();
    end
    $display("random bursts done");
    do_reset(2);
    conclude();
  end
endmodule
